// ==== pkg/pcs_codec_pkg.sv ====
// constants, types and code-group table for the 100 Mb/s line codec
// Summary of operation
// - transmit scrambled serial bits are NRZI encoded before MLT-3 conversion.
// - NRZI ones alternate between two binary driver streams.
// - at 100 Mb/s only MLT-3 symbols leave the line driver; no binary mode.
// - signal detect stays low while only 10M link pulses or FLPs arrive.
// - received three-level MLT-3 levels are turned into an NRZI bit stream.
// - NRZI bits are decoded to NRZ and fed to the descrambler.
// - received bits are grouped into 5-bit symbols for the receive PCS.
// - descrambler regenerates the key stream and XORs it with received bits.
// - lock after 12 consecutive idle groups (11111), then emit unaligned groups.
// - 722 us hold timer restarts whenever 58 idle bit times are seen.
// - hold timer expiry drops lock, resets descrambler and restarts acquisition.
// - aligner input is descrambler output, or NRZ decoder output when bypassed.
// - start pair 11000 10001 fixes the 5-bit symbol boundary.
// - start pair after idle is replaced by preamble nibbles 0101 0101.
// - after start, every code-group is table-translated to a nibble.
// - decoding stops on the end pair or two idle code-groups.
// - key stream comes from an 11-bit LFSR, fed from received bits while hunting and closed-loop once locked.
// - control code-groups inside data decode as invalid with receive error.
// - bad start pair gives RX_ER and nibble 1110 until two idles.
package pcs_codec_pkg;
  localparam int CLK_PERIOD_PS = 8000;
  localparam int HOLD_TIME_US = 722;
  localparam int HOLD_CYC = (HOLD_TIME_US * 1000000) / CLK_PERIOD_PS;
  localparam int SD_QUAL_NS = 800;
  localparam int SD_QUAL_CYC = (SD_QUAL_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
  localparam int SD_GAP_NS = 160;
  localparam int SD_GAP_CYC = (SD_GAP_NS * 1000) / CLK_PERIOD_PS;
  localparam int SYM_BITS = 5;
  localparam int PAIR_BITS = 2 * SYM_BITS;
  localparam int IDLE_SYNC_GROUPS = 12;
  localparam int IDLE_SYNC_BITS = IDLE_SYNC_GROUPS * SYM_BITS;
  localparam int IDLE_HOLD_BITS = 58;
  localparam int LFSR_LEN = 11;
  localparam int LFSR_TAP_A = 10;
  localparam int LFSR_TAP_B = 8;
  localparam logic [4:0] CG_IDLE = 5'h1f;
  localparam logic [4:0] CG_J = 5'h18;
  localparam logic [4:0] CG_K = 5'h11;
  localparam logic [4:0] CG_T = 5'h0d;
  localparam logic [4:0] CG_R = 5'h07;
  localparam logic [9:0] JK_PAIR = {CG_J, CG_K};
  localparam logic [3:0] NIB_PREAMBLE = 4'h5;
  localparam logic [3:0] NIB_BAD_SSD = 4'he;
  localparam logic [3:0] NIB_INVALID = 4'h0;
  localparam logic [1:0] MLT_ZERO_UP = 2'h0;
  localparam logic [1:0] MLT_POS = 2'h1;
  localparam logic [1:0] MLT_ZERO_DN = 2'h2;
  localparam logic [1:0] MLT_NEG = 2'h3;

  typedef enum logic [1:0] {RX_IDLE, RX_PACKET, RX_BAD_SSD} rx_state_t;

  // returns {is_data, nibble}
  function automatic logic [4:0] cg_decode(input logic [4:0] cg);
    logic [4:0] r;
    r = {1'b0, NIB_INVALID};
    case (cg)
      5'h1e: r = {1'b1, 4'h0};
      5'h09: r = {1'b1, 4'h1};
      5'h14: r = {1'b1, 4'h2};
      5'h15: r = {1'b1, 4'h3};
      5'h0a: r = {1'b1, 4'h4};
      5'h0b: r = {1'b1, 4'h5};
      5'h0e: r = {1'b1, 4'h6};
      5'h0f: r = {1'b1, 4'h7};
      5'h12: r = {1'b1, 4'h8};
      5'h13: r = {1'b1, 4'h9};
      5'h16: r = {1'b1, 4'ha};
      5'h17: r = {1'b1, 4'hb};
      5'h1a: r = {1'b1, 4'hc};
      5'h1b: r = {1'b1, 4'hd};
      5'h1c: r = {1'b1, 4'he};
      5'h1d: r = {1'b1, 4'hf};
      default: r = {1'b0, NIB_INVALID};
    endcase
    return r;
  endfunction : cg_decode
endpackage : pcs_codec_pkg

// ==== pkg/scr_link_if.sv ====
// link between the receive core and the descrambler
`timescale 1ns/1ps
interface scr_link_if;
  logic scr_bit;
  logic restart;
  logic plain_bit;
  logic locked;
  modport desc (input scr_bit, input restart, output plain_bit, output locked);
  modport core (output scr_bit, output restart, input plain_bit, input locked);
endinterface : scr_link_if

// ==== hw/tx_mlt3_encoder.sv ====
// transmit NRZI encoder and two-stream MLT-3 splitter
`timescale 1ns/1ps
module tx_mlt3_encoder
  import pcs_codec_pkg::*;
(
  input wire logic clk,
  input wire logic nrst,
  input wire logic scr_bit,
  output logic pos,
  output logic neg
);
  logic nrzi_reg;
  logic nrzi_next;
  logic step;
  logic [1:0] phase_reg;
  logic [1:0] phase_next;
  logic pos_reg;
  logic neg_reg;

  assign nrzi_next = nrzi_reg ^ scr_bit;
  assign step = nrzi_next ^ nrzi_reg;
  assign phase_next = step ? phase_reg + 2'h1 : phase_reg;

  // no binary path exists, the driver only ever sees these two streams
  always_ff @(posedge clk) begin
    if (!nrst) begin
      nrzi_reg <= 1'b0;
      phase_reg <= MLT_ZERO_UP;
      pos_reg <= 1'b0;
      neg_reg <= 1'b0;
    end else begin
      nrzi_reg <= nrzi_next;
      phase_reg <= phase_next;
      pos_reg <= (phase_next == MLT_POS);
      neg_reg <= (phase_next == MLT_NEG);
    end
  end

  assign pos = pos_reg;
  assign neg = neg_reg;
endmodule : tx_mlt3_encoder

// ==== hw/rx_descrambler.sv ====
// receive descrambler with idle lock and hold timer
`timescale 1ns/1ps
module rx_descrambler
  import pcs_codec_pkg::*;
#(
  parameter int HOLD_CYCLES = HOLD_CYC
) (
  input wire logic clk,
  input wire logic nrst,
  scr_link_if.desc link
);
  localparam int HW = $clog2(HOLD_CYCLES + 1);
  logic [LFSR_LEN-1:0] lfsr_reg;
  logic [LFSR_LEN-1:0] lfsr_next;
  logic key;
  logic match;
  logic plain_now;
  logic [5:0] match_cnt_reg;
  logic [5:0] idle_run_reg;
  logic [HW-1:0] hold_reg;
  logic locked_reg;
  logic plain_reg;
  logic acquired;
  logic refresh;
  logic expired;

  assign key = lfsr_reg[LFSR_TAP_A] ^ lfsr_reg[LFSR_TAP_B];
  // while hunting the plain data is taken as idle ones, so the key is ~scr
  assign lfsr_next = locked_reg ? {lfsr_reg[LFSR_LEN-2:0], key}
                                : {lfsr_reg[LFSR_LEN-2:0], ~link.scr_bit};
  assign plain_now = link.scr_bit ^ key;
  assign match = plain_now;
  assign acquired = !locked_reg && match && (match_cnt_reg == 6'(IDLE_SYNC_BITS - 1));
  assign refresh = plain_now && (idle_run_reg == 6'(IDLE_HOLD_BITS - 1));
  assign expired = locked_reg && (hold_reg == '0) && !refresh;

  always_ff @(posedge clk) begin
    if (!nrst || link.restart || expired) begin
      lfsr_reg <= '0;
      match_cnt_reg <= '0;
      idle_run_reg <= '0;
      hold_reg <= '0;
      locked_reg <= 1'b0;
      plain_reg <= 1'b0;
    end else begin
      lfsr_reg <= lfsr_next;
      match_cnt_reg <= match ? match_cnt_reg + 6'h1 : 6'h0;
      idle_run_reg <= (plain_now && !refresh) ? idle_run_reg + 6'h1 : 6'h0;
      plain_reg <= plain_now;
      if (acquired || (locked_reg && refresh)) begin
        hold_reg <= HW'(HOLD_CYCLES - 1);
      end else if (locked_reg) begin
        hold_reg <= hold_reg - HW'(1);
      end
      if (acquired) begin
        locked_reg <= 1'b1;
      end
    end
  end

  assign link.plain_bit = plain_reg;
  assign link.locked = locked_reg;
endmodule : rx_descrambler

// ==== hw/line_codec_top.sv ====
// 100 Mb/s line codec: tx MLT-3 path and rx decode, align, 5B/4B
`timescale 1ns/1ps
module line_codec_top
  import pcs_codec_pkg::*;
#(
  parameter int HOLD_CYCLES = HOLD_CYC
) (
  input wire logic CLK_SYS,
  input wire logic NRST,
  input wire logic TX_SCR_BIT,
  output logic TX_LINE_POS,
  output logic TX_LINE_NEG,
  input wire logic RX_LVL_POS,
  input wire logic RX_LVL_NEG,
  input wire logic RX_LINK_PULSE,
  input wire logic SCR_BYPASS,
  output logic SIGNAL_DETECT,
  output logic DESCR_LOCKED,
  output logic [4:0] RX_SYMBOL,
  output logic RX_SYMBOL_VALID,
  output logic RX_ALIGNED,
  output logic [3:0] RXD,
  output logic RX_NIB_VALID,
  output logic RX_DV,
  output logic RX_ER,
  output logic CRS
);
  localparam int QW = $clog2(SD_QUAL_CYC + 1);
  localparam int GW = $clog2(SD_GAP_CYC + 1);

  // ---------------- transmit ----------------
  tx_mlt3_encoder u_tx (
    .clk(CLK_SYS),
    .nrst(NRST),
    .scr_bit(TX_SCR_BIT),
    .pos(TX_LINE_POS),
    .neg(TX_LINE_NEG)
  );

  // ---------------- MLT-3 to NRZI to NRZ ----------------
  logic [1:0] lvl_reg;
  logic [1:0] lvl_now;
  logic lvl_change;
  logic nrzi_reg;
  logic nrzi_prev_reg;
  logic nrz_reg;

  assign lvl_now = {RX_LVL_POS, RX_LVL_NEG};
  // any level change on the line is one NRZI transition
  assign lvl_change = (lvl_now != lvl_reg);

  always_ff @(posedge CLK_SYS) begin
    if (!NRST) begin
      lvl_reg <= 2'h0;
      nrzi_reg <= 1'b0;
      nrzi_prev_reg <= 1'b0;
      nrz_reg <= 1'b0;
    end else begin
      lvl_reg <= lvl_now;
      nrzi_reg <= nrzi_reg ^ lvl_change;
      nrzi_prev_reg <= nrzi_reg;
      nrz_reg <= nrzi_reg ^ nrzi_prev_reg;
    end
  end

  // ---------------- signal detect ----------------
  // a 100 ns link pulse or a sparse FLP burst can never keep transitions
  // coming for the whole qualification time, so those never qualify
  logic [GW-1:0] gap_reg;
  logic [QW-1:0] qual_reg;
  logic sd_reg;
  logic gap_ok;
  logic qual_done;

  assign gap_ok = (gap_reg < GW'(SD_GAP_CYC)) && !RX_LINK_PULSE;
  assign qual_done = (qual_reg == QW'(SD_QUAL_CYC));

  always_ff @(posedge CLK_SYS) begin
    if (!NRST) begin
      gap_reg <= '0;
      qual_reg <= '0;
      sd_reg <= 1'b0;
    end else begin
      if (lvl_change) begin
        gap_reg <= '0;
      end else if (gap_reg != GW'(SD_GAP_CYC)) begin
        gap_reg <= gap_reg + GW'(1);
      end
      if (!gap_ok) begin
        qual_reg <= '0;
      end else if (!qual_done) begin
        qual_reg <= qual_reg + QW'(1);
      end
      sd_reg <= gap_ok && (qual_done || sd_reg);
    end
  end

  // ---------------- descrambler ----------------
  scr_link_if scr_link ();

  assign scr_link.scr_bit = nrz_reg;
  assign scr_link.restart = !sd_reg;

  rx_descrambler #(
    .HOLD_CYCLES(HOLD_CYCLES)
  ) u_desc (
    .clk(CLK_SYS),
    .nrst(NRST),
    .link(scr_link)
  );

  // ---------------- stream select ----------------
  logic stream_bit;
  logic stream_ok;

  assign stream_bit = SCR_BYPASS ? nrz_reg : scr_link.plain_bit;
  assign stream_ok = sd_reg && (SCR_BYPASS || scr_link.locked);

  // ---------------- serial to parallel and alignment ----------------
  logic [PAIR_BITS-1:0] win_reg;
  logic [PAIR_BITS-1:0] win_next;
  logic [2:0] phase_reg;
  logic jk_hit;
  logic sym_strobe;
  logic [4:0] cur_sym;
  logic aligned_reg;
  logic [4:0] sym_reg;
  logic sym_valid_reg;

  // first received bit ends up as the msb of a code-group
  assign win_next = {win_reg[PAIR_BITS-2:0], stream_bit};
  assign jk_hit = stream_ok && (win_next == JK_PAIR);
  assign sym_strobe = stream_ok && (jk_hit || (phase_reg == 3'(SYM_BITS - 1)));
  assign cur_sym = win_next[SYM_BITS-1:0];

  always_ff @(posedge CLK_SYS) begin
    if (!NRST) begin
      win_reg <= '0;
      phase_reg <= '0;
      aligned_reg <= 1'b0;
      sym_reg <= '0;
      sym_valid_reg <= 1'b0;
    end else begin
      win_reg <= win_next;
      phase_reg <= (sym_strobe || !stream_ok) ? 3'h0 : phase_reg + 3'h1;
      aligned_reg <= stream_ok && (aligned_reg || jk_hit);
      sym_valid_reg <= sym_strobe;
      if (sym_strobe) begin
        sym_reg <= cur_sym;
      end
    end
  end

  // ---------------- idle tracking ----------------
  // ones_reg saturates at a full pair: two idle groups in a row
  logic [3:0] ones_reg;
  logic [3:0] ones_next;
  logic line_idle;
  logic [3:0] brk_reg;
  logic armed_reg;
  logic brk_over;

  assign ones_next = !stream_bit ? 4'h0 :
                     (ones_reg == 4'(PAIR_BITS)) ? ones_reg : ones_reg + 4'h1;
  assign line_idle = (ones_reg == 4'(PAIR_BITS));
  assign brk_over = armed_reg && (brk_reg == 4'(PAIR_BITS));

  // ---------------- code-group decoder ----------------
  rx_state_t state_reg;
  rx_state_t state_next;
  logic [4:0] last_sym_reg;
  logic [4:0] dec;
  logic end_pair;
  logic end_idle;
  logic start_ok;
  logic [3:0] held_nib_reg;
  logic held_err_reg;
  logic [3:0] rxd_reg;
  logic rx_dv_reg;
  logic rx_er_reg;
  logic nib_valid_reg;

  assign dec = cg_decode(cur_sym);
  assign end_pair = (last_sym_reg == CG_T) && (cur_sym == CG_R);
  assign end_idle = (last_sym_reg == CG_IDLE) && (cur_sym == CG_IDLE);
  assign start_ok = jk_hit && armed_reg;

  always_comb begin
    state_next = state_reg;
    case (state_reg)
      RX_IDLE: begin
        if (start_ok) begin
          state_next = RX_PACKET;
        end else if (brk_over) begin
          state_next = RX_BAD_SSD;
        end
      end
      RX_PACKET: begin
        if (sym_strobe && (end_pair || end_idle)) begin
          state_next = RX_IDLE;
        end
      end
      RX_BAD_SSD: begin
        if (line_idle) begin
          state_next = RX_IDLE;
        end
      end
      default: state_next = RX_IDLE;
    endcase
    if (!stream_ok) begin
      state_next = RX_IDLE;
    end
  end

  always_ff @(posedge CLK_SYS) begin
    if (!NRST) begin
      ones_reg <= '0;
      brk_reg <= '0;
      armed_reg <= 1'b0;
    end else begin
      ones_reg <= stream_ok ? ones_next : 4'h0;
      if (ones_next == 4'(PAIR_BITS)) begin
        brk_reg <= '0;
      end else if (brk_reg != 4'(PAIR_BITS)) begin
        brk_reg <= brk_reg + 4'h1;
      end
      if (!stream_ok || state_reg != RX_IDLE || brk_over) begin
        armed_reg <= 1'b0;
      end else if (ones_next == 4'(PAIR_BITS)) begin
        armed_reg <= 1'b1;
      end
    end
  end

  // nibbles leave one symbol late so the K slot can still carry preamble
  always_ff @(posedge CLK_SYS) begin
    if (!NRST) begin
      state_reg <= RX_IDLE;
      last_sym_reg <= '0;
      held_nib_reg <= '0;
      held_err_reg <= 1'b0;
      rxd_reg <= '0;
      rx_dv_reg <= 1'b0;
      rx_er_reg <= 1'b0;
      nib_valid_reg <= 1'b0;
    end else begin
      state_reg <= state_next;
      nib_valid_reg <= sym_strobe;
      if (sym_strobe) begin
        last_sym_reg <= cur_sym;
      end
      if (state_next == RX_IDLE) begin
        rx_dv_reg <= 1'b0;
        rx_er_reg <= 1'b0;
      end else if (state_reg == RX_IDLE && state_next == RX_PACKET) begin
        rxd_reg <= NIB_PREAMBLE;
        held_nib_reg <= NIB_PREAMBLE;
        held_err_reg <= 1'b0;
        rx_dv_reg <= 1'b1;
        rx_er_reg <= 1'b0;
      end else if (state_next == RX_BAD_SSD) begin
        if (sym_strobe || state_reg == RX_IDLE) begin
          rxd_reg <= NIB_BAD_SSD;
          rx_er_reg <= 1'b1;
          rx_dv_reg <= 1'b0;
        end
      end else if (sym_strobe) begin
        rxd_reg <= held_nib_reg;
        rx_er_reg <= held_err_reg;
        rx_dv_reg <= 1'b1;
        held_nib_reg <= dec[3:0];
        held_err_reg <= !dec[4];
      end
    end
  end

  // ---------------- outputs ----------------
  assign SIGNAL_DETECT = sd_reg;
  assign DESCR_LOCKED = scr_link.locked;
  assign RX_SYMBOL = sym_reg;
  assign RX_SYMBOL_VALID = sym_valid_reg;
  assign RX_ALIGNED = aligned_reg;
  assign RXD = rxd_reg;
  assign RX_NIB_VALID = nib_valid_reg;
  assign RX_DV = rx_dv_reg;
  assign RX_ER = rx_er_reg;
  assign CRS = (state_reg != RX_IDLE);
endmodule : line_codec_top

// ==== verification/line_partner.sv ====
// far-end line driver model: scrambles, NRZI codes and MLT-3 steps a plain bit stream
`timescale 1ns/1ps
module line_partner
  import pcs_codec_pkg::*;
(
  input wire logic clk,
  input wire logic plain_bit,
  input wire logic scramble,
  output logic lvl_pos,
  output logic lvl_neg
);
  // seed is arbitrary; the receiver must acquire from any nonzero start
  logic [10:0] key_reg = 11'h5a3;
  logic [1:0] phase_reg = 2'h0;
  wire logic key = key_reg[LFSR_TAP_A] ^ key_reg[LFSR_TAP_B];
  wire logic line_bit = scramble ? plain_bit ^ key : plain_bit;
  always @(posedge clk) begin
    key_reg <= {key_reg[9:0], key};
    if (line_bit) begin
      phase_reg <= phase_reg + 2'h1;
    end
  end
  assign lvl_pos = phase_reg == MLT_POS;
  assign lvl_neg = phase_reg == MLT_NEG;
endmodule : line_partner

// ==== verification/line_codec_assertions.sv ====
// port-level assertions for the line codec top
`timescale 1ns/1ps
module line_codec_assertions
  import pcs_codec_pkg::*;
#(
  parameter int HOLD_CYCLES = HOLD_CYC
) (
  input wire logic CLK_SYS,
  input wire logic NRST,
  input wire logic TX_SCR_BIT,
  input wire logic TX_LINE_POS,
  input wire logic TX_LINE_NEG,
  input wire logic RX_LINK_PULSE,
  input wire logic SIGNAL_DETECT,
  input wire logic DESCR_LOCKED,
  input wire logic RX_SYMBOL_VALID,
  input wire logic RX_ALIGNED,
  input wire logic [3:0] RXD,
  input wire logic RX_DV,
  input wire logic RX_ER,
  input wire logic CRS
);
  logic last_neg_reg;
  default clocking cb @(posedge CLK_SYS); endclocking
  default disable iff (!NRST);
  // remembers the last driven side so the next excursion must use the other one
  always_ff @(posedge CLK_SYS) begin
    if (!NRST) begin
      last_neg_reg <= 1'b1;
    end else if (TX_LINE_POS) begin
      last_neg_reg <= 1'b0;
    end else if (TX_LINE_NEG) begin
      last_neg_reg <= 1'b1;
    end
  end
  tx_one_side_a: assert property (!(TX_LINE_POS && TX_LINE_NEG))
    else $error("both line streams high");
  tx_hold_zero_a: assert property ($past(NRST) && !TX_SCR_BIT |=>
    $stable({TX_LINE_POS, TX_LINE_NEG})) else $error("line level moved on a zero");
  tx_leave_side_a: assert property (TX_SCR_BIT && (TX_LINE_POS || TX_LINE_NEG) |=>
    !TX_LINE_POS && !TX_LINE_NEG) else $error("line did not return to zero");
  tx_alternate_a: assert property (TX_SCR_BIT && !TX_LINE_POS && !TX_LINE_NEG |=>
    TX_LINE_POS == last_neg_reg && TX_LINE_POS != TX_LINE_NEG) else $error("side not swapped");
  detect_pulse_a: assert property (RX_LINK_PULSE [*2] |-> !SIGNAL_DETECT)
    else $error("detect high during link pulses");
  quiet_rx_a: assert property (!SIGNAL_DETECT [*8] |-> !RX_SYMBOL_VALID && !RX_DV)
    else $error("symbols without signal");
  lock_drop_a: assert property (!SIGNAL_DETECT [*3] |-> !DESCR_LOCKED)
    else $error("lock kept without signal");
  dv_start_a: assert property ($rose(RX_DV) |-> RX_ALIGNED && CRS &&
    RXD == NIB_PREAMBLE && !RX_ER) else $error("packet start nibble wrong");
  invalid_nib_a: assert property (RX_DV && RX_ER |-> RXD == NIB_INVALID)
    else $error("invalid group nibble wrong");
  bad_ssd_a: assert property (RX_ER && !RX_DV |-> RXD == NIB_BAD_SSD)
    else $error("false carrier nibble wrong");
  dv_end_a: assert property ($fell(RX_DV) |-> !CRS)
    else $error("carrier kept after packet end");
endmodule : line_codec_assertions

// ==== verification/tb_line_codec_top.sv ====
// self-checking bench for the line codec top
`timescale 1ns/1ps
module tb_line_codec_top
  import pcs_codec_pkg::*;
;
  logic clk = 1'b0, nrst = 1'b0, tx_bit = 1'b0, plain = 1'b1, pulse = 1'b0, byp = 1'b0;
  logic pos, neg, lp, ln, sd, lock, symv, alig, nibv, dv, er, crs;
  logic [4:0] sym;
  logic [3:0] rxd;
  logic [4:0] got[$], exp[$], body[$];
  int bad_count = 0, n_tests = 0;
  logic [4:0] enc [16] = '{5'h1e, 5'h09, 5'h14, 5'h15, 5'h0a, 5'h0b, 5'h0e, 5'h0f,
    5'h12, 5'h13, 5'h16, 5'h17, 5'h1a, 5'h1b, 5'h1c, 5'h1d};
  // rows: {scrambled bit, expected pos, expected neg}
  logic [2:0] tx_rows [8] = '{3'h6, 3'h2, 3'h4, 3'h5, 3'h1, 3'h4, 3'h6, 3'h4};
  always #4 clk = ~clk;
  line_partner far (.clk(clk), .plain_bit(plain), .scramble(!byp), .lvl_pos(lp), .lvl_neg(ln));
  line_codec_top #(.HOLD_CYCLES(300)) DUT (.CLK_SYS(clk), .NRST(nrst), .TX_SCR_BIT(tx_bit),
    .TX_LINE_POS(pos), .TX_LINE_NEG(neg), .RX_LVL_POS(lp), .RX_LVL_NEG(ln),
    .RX_LINK_PULSE(pulse), .SCR_BYPASS(byp), .SIGNAL_DETECT(sd), .DESCR_LOCKED(lock),
    .RX_SYMBOL(sym), .RX_SYMBOL_VALID(symv), .RX_ALIGNED(alig), .RXD(rxd),
    .RX_NIB_VALID(nibv), .RX_DV(dv), .RX_ER(er), .CRS(crs));
  always @(negedge clk) if (nibv === 1'b1 && (dv === 1'b1 || er === 1'b1)) got.push_back({er, rxd});
  function automatic logic [19:0] outs();
    return {1'b0, pos, neg, sd, lock, symv, alig, nibv, dv, er, crs, rxd, sym};
  endfunction : outs
  task automatic check(input logic [19:0] seen, input logic [19:0] want);
    n_tests++;
    if (seen !== want) begin
      bad_count++;
      $display("unexpected at %0t: got %h, expected %h", $time, seen, want);
    end
  endtask : check
  task automatic send(input logic [4:0] g);
    for (int i = 4; i >= 0; i--) begin
      @(negedge clk);
      plain = g[i];
    end
  endtask : send
  task automatic idle(input int n);
    @(negedge clk);
    plain = 1'b1;
    repeat (5 * n) @(negedge clk);
  endtask : idle
  task automatic frame(input logic [9:0] tail);
    send(CG_J);
    send(CG_K);
    foreach (body[i]) send(body[i]);
    send(tail[9:5]);
    send(tail[4:0]);
    // a tail of 60 idle ones refreshes the descrambler hold timer after every frame
    idle(12);
  endtask : frame
  task automatic verify();
    check(20'(got.size()), 20'(exp.size()));
    foreach (exp[i]) check(20'(got[i]), 20'(exp[i]));
    got.delete();
    exp.delete();
  endtask : verify
  // an idle line descrambles to all ones, so any symbol slot should read 11111
  task automatic sym_chk();
    for (int k = 0; k < 12 && symv !== 1'b1; k++) @(negedge clk);
    check(20'(sym), 20'h1f);
  endtask : sym_chk
  task automatic end_of_test();
    $display("checks %0d, mismatches %0d", n_tests, bad_count);
    if (bad_count == 0 && n_tests > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask : end_of_test
  initial begin
    #200000;
    bad_count++;
    end_of_test();
  end
  initial begin
    repeat (4) @(negedge clk);
    check(outs(), 20'h0);
    repeat (4) @(negedge clk);
    nrst = 1'b1;
    foreach (tx_rows[i]) begin
      tx_bit = tx_rows[i][2];
      @(negedge clk);
      check(20'({pos, neg}), 20'(tx_rows[i][1:0]));
    end
    tx_bit = 1'b0;
    pulse = 1'b1;
    idle(30);
    check(20'(sd), 20'h0);
    pulse = 1'b0;
    idle(60);
    check(20'({sd, lock}), 20'h3);
    sym_chk();
    exp = '{5'h05, 5'h05};
    foreach (enc[i]) begin
      body.push_back(enc[i]);
      exp.push_back(5'(i));
    end
    frame({CG_T, CG_R});
    verify();
    body = '{enc[1], CG_R, enc[2]};
    exp = '{5'h05, 5'h05, 5'h01, 5'h10, 5'h02};
    frame({CG_T, CG_R});
    verify();
    body = '{enc[3]};
    exp = '{5'h05, 5'h05, 5'h03};
    frame({CG_IDLE, CG_IDLE});
    verify();
    check(20'(crs), 20'h0);
    send(5'h0a);
    send(5'h0b);
    // long enough idle to refresh the hold timer before the busy gaps below
    idle(14);
    check(20'(got.size() > 0), 20'h1);
    foreach (got[i]) check(20'(got[i]), 20'h1e);
    check(20'({er, crs}), 20'h0);
    // busy gaps shorter than the hold window, each followed by enough idle
    repeat (3) begin
      repeat (40) send(5'h0a);
      idle(14);
    end
    check(20'(lock), 20'h1);
    repeat (80) send(5'h0a);
    check(20'(lock), 20'h0);
    idle(40);
    check(20'(lock), 20'h1);
    pulse = 1'b1;
    idle(2);
    check(20'({sd, lock}), 20'h0);
    pulse = 1'b0;
    byp = 1'b1;
    got.delete();
    idle(30);
    sym_chk();
    body = '{enc[9], enc[10]};
    exp = '{5'h05, 5'h05, 5'h09, 5'h0a};
    frame({CG_T, CG_R});
    verify();
    tx_bit = 1'b1;
    nrst = 1'b0;
    repeat (2) @(negedge clk);
    check(outs(), 20'h0);
    end_of_test();
  end
endmodule : tb_line_codec_top
bind line_codec_top line_codec_assertions #(.HOLD_CYCLES(HOLD_CYCLES)) chk (.*);
